// >>> rtl/cmc_mode_control.sv
// cmc_mode_control: primary mode control and status of a bus controller
// assumes the protocol engine reports bit ticks and frame events as
// single-cycle pulses synchronous to i_core_clk
//
// Functional notes
// - received-frame flag bit 7 sets on each valid received message.
// - writing one clears the received-frame flag; writing zero does nothing.
// - received-frame and receiver-active bits are undefined in loopback.
// - bit 6 shows the receiver front end is receiving a message.
// - bit 5 set stops host interface clocks during wait mode.
// - bit 4 shows synchronisation to the bus, kept by hardware.
// - bit 3 runs a 16-bit counter at bit rate.
// - at valid end of frame the stamp goes to the active buffer.
// - counter clears when disabled; timer enable held low in init.
// - wake enable lets bus traffic end sleep; set before sleeping.
// - sleep entered only when bus idle, then sleep acknowledge rises.
// - sleep request cannot be set while wake-up flag is set.
// - sleep lasts until software clears it or bus activity wakes.
// - init request aborts traffic, drops sync, then acknowledges.
// - entering init resets flag, enable, abort and select registers.
// - configuration registers writable only in initialization mode.
// - after init leaves, sync after 11 recessive bits, or 128 runs.
// - primary control writable outside init; status bits read only.
// - in init primary bits except wake, sleep, init held reset.
// - clearing sleep request ignored until sleep entered.
// - clearing init request ignored until init entered.
// - transmit pin forced recessive as soon as init requested.
`timescale 1ns/1ps
module cmc_mode_control (
   input  wire logic                i_core_clk,
   input  wire logic                i_sys_rst,
   input  wire cmc_pkg::cmc_bus_type i_bus,
   output logic [7:0]               o_rdata,
   input  wire logic                i_rx_active,
   input  wire logic                i_rx_valid_frame,
   input  wire logic                i_eof_valid,
   input  wire logic                i_bit_tick,
   input  wire logic                i_recessive_bit,
   input  wire logic                i_bus_off,
   input  wire logic                i_bus_activity,
   input  wire logic                i_tx_empty,
   input  wire logic                i_wake_flag,
   input  wire logic                i_wait_mode,
   input  wire logic                i_tx_data,
   output logic                     o_bus_transmit_pin,
   output logic                     o_host_clk_stop,
   output logic                     o_proto_abort,
   output logic                     o_init_regs_reset,
   output logic                     o_wake_event,
   output logic [15:0]              o_stamp,
   output logic                     o_stamp_wr,
   output logic [7:0]               o_secondary,
   output logic [7:0]               o_gated_config
);
   cmc_pkg::cmc_state_type s_r;
   cmc_pkg::cmc_state_type s_nxt;
   logic in_init;
   logic wr_prim;
   logic [7:0] wd;
   logic [7:0] prim_view;

   assign in_init = s_r.init_rq & s_r.init_ak;
   assign wr_prim = i_bus.wr & (i_bus.addr == cmc_pkg::ADDR_PRIMARY_CONTROL);
   assign wd      = i_bus.wdata;

   // read view of the primary control register
   always_comb begin
      prim_view = 8'h00;
      // loopback not modelled, both bits simply follow the receiver
      prim_view[cmc_pkg::BIT_RECEIVED_FRAME_FLAG] = s_r.received_frame_flag;
      prim_view[cmc_pkg::BIT_RECEIVER_ACTIVE_STATUS] = i_rx_active & ~in_init;
      prim_view[cmc_pkg::BIT_CSTOP] = s_r.cstop;
      prim_view[cmc_pkg::BIT_SYNC]  = s_r.sync;
      prim_view[cmc_pkg::BIT_TIMER] = s_r.timer_en;
      prim_view[cmc_pkg::BIT_WAKE]  = s_r.wake_en;
      prim_view[cmc_pkg::BIT_SLEEP] = s_r.sleep_rq;
      prim_view[cmc_pkg::BIT_INIT]  = s_r.init_rq;
   end

   // next state of the whole block
   always_comb begin
      s_nxt = s_r;
      s_nxt.stamp_wr = 1'b0;
      // set flag, set wins over clear
      if (wr_prim && wd[cmc_pkg::BIT_RECEIVED_FRAME_FLAG] && !in_init)
         s_nxt.received_frame_flag = 1'b0;
      if (i_rx_valid_frame && !s_r.init_rq)
         s_nxt.received_frame_flag = 1'b1;
      if (wr_prim && !s_r.init_rq && !s_r.init_ak) begin
         s_nxt.cstop    = wd[cmc_pkg::BIT_CSTOP];
         s_nxt.timer_en = wd[cmc_pkg::BIT_TIMER];
         s_nxt.wake_en  = wd[cmc_pkg::BIT_WAKE];
      end
      if (wr_prim) begin
         // sleep set refused with wake flag
         if (wd[cmc_pkg::BIT_SLEEP] && !i_wake_flag && !s_r.init_rq)
            s_nxt.sleep_rq = 1'b1;
         if (!wd[cmc_pkg::BIT_SLEEP] && s_r.sleep_rq && s_r.sleep_ak)
            s_nxt.sleep_rq = 1'b0;
         if (wd[cmc_pkg::BIT_INIT])
            s_nxt.init_rq = 1'b1;
         // init clear only once in init
         else if (in_init)
            s_nxt.init_rq = 1'b0;
      end
      if (s_r.timer_en && i_bit_tick)
         s_nxt.stamp = s_r.stamp + 16'h0001;
      if (!s_r.timer_en)
         s_nxt.stamp = cmc_pkg::STAMP_ZERO;
      // capture at valid end of frame
      if (s_r.timer_en && i_eof_valid) begin
         s_nxt.stamp_out = s_r.stamp;
         s_nxt.stamp_wr  = 1'b1;
      end
      if (i_bus.wr && in_init) begin
         if (i_bus.addr == cmc_pkg::ADDR_SECONDARY_CONTROL)
            s_nxt.secondary = wd;
         if (i_bus.addr == cmc_pkg::ADDR_GATED_CONFIG)
            s_nxt.gated = wd;
      end
      unique case (s_r.mode)
         cmc_pkg::CMC_RUN: begin
            if (s_r.init_rq) begin
               s_nxt.mode    = cmc_pkg::CMC_INIT;
               s_nxt.init_ak = 1'b1;
               s_nxt.sync    = 1'b0;
            end else if (s_r.sleep_rq && !i_rx_active && i_tx_empty) begin
               s_nxt.mode     = cmc_pkg::CMC_SLEEP;
               s_nxt.sleep_ak = 1'b1;
            end else begin
               s_nxt.sync = ~i_bus_off;
            end
         end
         cmc_pkg::CMC_SLEEP: begin
            if (s_r.init_rq) begin
               s_nxt.mode     = cmc_pkg::CMC_INIT;
               s_nxt.init_ak  = 1'b1;
               s_nxt.sleep_ak = 1'b0;
               s_nxt.sync     = 1'b0;
            end else if (!s_r.sleep_rq) begin
               s_nxt.mode     = cmc_pkg::CMC_RUN;
               s_nxt.sleep_ak = 1'b0;
            end else if (s_r.wake_en && i_bus_activity) begin
               s_nxt.sleep_rq = 1'b0;
               s_nxt.sleep_ak = 1'b0;
               s_nxt.mode     = cmc_pkg::CMC_RUN;
            end
         end
         cmc_pkg::CMC_INIT: begin
            s_nxt.sync = 1'b0;
            if (!s_r.init_rq) begin
               s_nxt.init_ak    = 1'b0;
               s_nxt.mode       = cmc_pkg::CMC_RESYNC;
               s_nxt.idle_cnt   = 4'h0;
               s_nxt.busoff_cnt = 8'h00;
            end
         end
         cmc_pkg::CMC_RESYNC: begin
            if (s_r.init_rq) begin
               s_nxt.mode    = cmc_pkg::CMC_INIT;
               s_nxt.init_ak = 1'b1;
            end else if (i_bit_tick) begin
               if (!i_recessive_bit)
                  s_nxt.idle_cnt = 4'h0;
               else if (s_r.idle_cnt == cmc_pkg::IDLE_BITS - 4'h1) begin
                  s_nxt.idle_cnt = 4'h0;
                  if (!i_bus_off ||
                      s_r.busoff_cnt == cmc_pkg::BUSOFF_IDLES - 8'h01) begin
                     s_nxt.mode = cmc_pkg::CMC_RUN;
                     s_nxt.sync = 1'b1;
                  end else
                     s_nxt.busoff_cnt = s_r.busoff_cnt + 8'h01;
               end else
                  s_nxt.idle_cnt = s_r.idle_cnt + 4'h1;
            end
         end
      endcase
      // held at reset while in init
      // timer enable forced low in init
      if (s_nxt.init_ak) begin
         s_nxt.received_frame_flag    = 1'b0;
         s_nxt.cstop    = 1'b0;
         s_nxt.timer_en = 1'b0;
      end
      // registered read data, one cycle after the strobe
      s_nxt.rdata = 8'h00;
      if (i_bus.rd) begin
         unique case (i_bus.addr)
            cmc_pkg::ADDR_PRIMARY_CONTROL:   s_nxt.rdata = prim_view;
            cmc_pkg::ADDR_SECONDARY_CONTROL: begin
               s_nxt.rdata = s_r.secondary;
               s_nxt.rdata[cmc_pkg::BIT_SLPACK]  = s_r.sleep_ak;
               s_nxt.rdata[cmc_pkg::BIT_INITACK] = s_r.init_ak;
            end
            cmc_pkg::ADDR_TIME_STAMP:        s_nxt.rdata = s_r.stamp[15:8];
            cmc_pkg::ADDR_GATED_CONFIG:      s_nxt.rdata = s_r.gated;
            default:                         s_nxt.rdata = 8'h00;
         endcase
      end
   end

   // state register
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         s_r            <= '0;
         s_r.init_rq    <= cmc_pkg::PRIMARY_RESET[cmc_pkg::BIT_INIT];
         s_r.init_ak    <= 1'b1;
         s_r.mode       <= cmc_pkg::CMC_INIT;
         s_r.secondary  <= cmc_pkg::SECONDARY_RESET;
         s_r.gated      <= cmc_pkg::GATED_RESET;
         s_r.stamp      <= cmc_pkg::STAMP_ZERO;
         s_r.stamp_out  <= cmc_pkg::STAMP_ZERO;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs
   assign o_rdata            = s_r.rdata;
   // recessive while init requested, stopped in wait, or in sleep
   assign o_bus_transmit_pin = (s_r.init_rq | (i_wait_mode & s_r.cstop) |
                                (s_r.mode == cmc_pkg::CMC_SLEEP)) ? 1'b1
                               : i_tx_data;
   // host clock stop in wait mode
   assign o_host_clk_stop    = i_wait_mode & s_r.cstop;
   assign o_proto_abort      = s_r.init_rq;
   // other flag registers reset in init
   assign o_init_regs_reset  = s_r.init_ak;
   assign o_wake_event       = (s_r.mode == cmc_pkg::CMC_SLEEP) &
                               s_r.wake_en & i_bus_activity;
   assign o_stamp            = s_r.stamp_out;
   assign o_stamp_wr         = s_r.stamp_wr;
   assign o_secondary        = s_r.secondary;
   assign o_gated_config     = s_r.gated;

   chk_timer_init_low: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) in_init |-> !s_r.timer_en)
      else $error("timer enable set in init");
   chk_sleep_refused: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (wr_prim && i_wake_flag && !s_r.sleep_rq) |=> !s_r.sleep_rq)
      else $error("sleep set with wake flag");
   chk_init_hold: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (s_r.init_rq && !s_r.init_ak) |=> s_r.init_rq)
      else $error("init request dropped early");
   chk_sleep_hold: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (s_r.sleep_rq && !s_r.sleep_ak && !s_r.init_rq) |=> s_r.sleep_rq)
      else $error("sleep request dropped early");
   chk_received_frame_flag_set: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (i_rx_valid_frame && !s_r.init_rq && !s_nxt.init_ak) |=> s_r.received_frame_flag)
      else $error("frame flag not set");
   chk_init_ack: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) $rose(s_r.init_rq) |-> ##[0:2] s_r.init_ak)
      else $error("init not acknowledged");
   chk_tx_recessive: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) s_r.init_rq |-> o_bus_transmit_pin)
      else $error("transmit pin not recessive");
   // stamp write follows end of frame
   chk_stamp_write: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (i_eof_valid && s_r.timer_en) |=> (o_stamp_wr && o_stamp == $past(s_r.stamp)))
      else $error("stamp not written");

   // sequences for the multi-step sleep handshake
   sequence seq_sleep_idle;
      s_r.mode == cmc_pkg::CMC_RUN && s_r.sleep_rq && !s_r.init_rq &&
      !i_rx_active && i_tx_empty;
   endsequence
   sequence seq_wake_traffic;
      s_r.mode == cmc_pkg::CMC_SLEEP && s_r.sleep_rq && !s_r.init_rq &&
      s_r.wake_en && i_bus_activity;
   endsequence

   chk_received_frame_flag_clear: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (wr_prim && wd[cmc_pkg::BIT_RECEIVED_FRAME_FLAG] && !i_rx_valid_frame) |=> !s_r.received_frame_flag)
      else $error("frame flag not cleared");
   chk_received_frame_flag_keep: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (s_r.received_frame_flag && !(wr_prim && wd[cmc_pkg::BIT_RECEIVED_FRAME_FLAG]) && !s_nxt.init_ak)
      |=> s_r.received_frame_flag)
      else $error("frame flag lost");
   chk_receiver_active_status_view: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (i_bus.rd && i_bus.addr == cmc_pkg::ADDR_PRIMARY_CONTROL && !in_init)
      |=> (o_rdata[cmc_pkg::BIT_RECEIVER_ACTIVE_STATUS] == $past(i_rx_active)))
      else $error("receiver active bit wrong");
   // host clocks stop only in wait
   chk_clk_stop: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      o_host_clk_stop == (i_wait_mode && s_r.cstop))
      else $error("host clock stop wrong");
   chk_sync_in_init: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      s_r.init_ak |-> !s_r.sync)
      else $error("sync shown in init");
   chk_stamp_count: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (s_r.timer_en && i_bit_tick) |=> (s_r.stamp == $past(s_r.stamp) + 16'h0001))
      else $error("stamp did not count");
   chk_stamp_clear: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      !s_r.timer_en |=> (s_r.stamp == cmc_pkg::STAMP_ZERO))
      else $error("stamp not cleared");
   chk_sleep_entry: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      seq_sleep_idle |=> s_r.sleep_ak)
      else $error("sleep not entered");
   chk_sleep_busy: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (s_r.mode == cmc_pkg::CMC_RUN && !s_r.sleep_ak &&
       (i_rx_active || !i_tx_empty)) |=> !s_r.sleep_ak)
      else $error("sleep entered while busy");
   chk_wake_exit: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      seq_wake_traffic |=> (!s_r.sleep_rq && !s_r.sleep_ak))
      else $error("sleep not left on traffic");
   chk_wake_event: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      !s_r.wake_en |-> !o_wake_event)
      else $error("wake without enable");
   chk_init_entry: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (s_r.init_rq && !s_r.init_ak) |=> s_r.init_ak)
      else $error("init not entered");
   chk_init_regs: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      in_init |-> o_init_regs_reset)
      else $error("registers not reset in init");
   chk_cfg_locked: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (i_bus.wr && !in_init) |=> ($stable(s_r.gated) && $stable(s_r.secondary)))
      else $error("configuration written outside init");
   chk_resync_nosync: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      s_r.mode == cmc_pkg::CMC_RESYNC |-> !s_r.sync)
      else $error("sync during resync");
   // wake enable bit locked with init request
   chk_prim_locked: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (wr_prim && s_r.init_rq) |=> $stable(s_r.wake_en))
      else $error("primary bit written in init");
endmodule : cmc_mode_control

// >>> rtl/cmc_pkg.sv
// cmc_pkg: constants and carrier types for the primary mode control block
// assumes a single 40 MHz core clock and a simple strobe register port
package cmc_pkg;
   // register map
   localparam logic [3:0] ADDR_PRIMARY_CONTROL   = 4'h0;
   localparam logic [3:0] ADDR_SECONDARY_CONTROL = 4'h1;
   localparam logic [3:0] ADDR_TIME_STAMP        = 4'h2;
   localparam logic [3:0] ADDR_GATED_CONFIG      = 4'h3;
   // primary control bit positions
   localparam int BIT_RECEIVED_FRAME_FLAG   = 7;
   localparam int BIT_RECEIVER_ACTIVE_STATUS   = 6;
   localparam int BIT_CSTOP   = 5;
   localparam int BIT_SYNC    = 4;
   localparam int BIT_TIMER   = 3;
   localparam int BIT_WAKE    = 2;
   localparam int BIT_SLEEP   = 1;
   localparam int BIT_INIT    = 0;
   // secondary control acknowledge positions
   localparam int BIT_SLPACK  = 1;
   localparam int BIT_INITACK = 0;
   localparam logic [7:0] PRIMARY_RESET   = 8'h01;
   localparam logic [7:0] SECONDARY_RESET = 8'h11;
   localparam logic [7:0] GATED_RESET     = 8'h00;
   // resynchronisation counts: bit times per idle run, then idle runs in bus off
   localparam logic [3:0] IDLE_BITS       = 4'hb;
   localparam logic [7:0] BUSOFF_IDLES    = 8'h80;
   localparam logic [15:0] STAMP_ZERO     = 16'h0000;

   typedef enum logic [1:0] {
      CMC_RUN,
      CMC_SLEEP,
      CMC_INIT,
      CMC_RESYNC
   } cmc_mode_type;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } cmc_bus_type;

   typedef struct packed {
      logic         received_frame_flag;
      logic         cstop;
      logic         timer_en;
      logic         wake_en;
      logic         sleep_rq;
      logic         init_rq;
      logic         sleep_ak;
      logic         init_ak;
      logic         sync;
      cmc_mode_type mode;
      logic [3:0]   idle_cnt;
      logic [7:0]   busoff_cnt;
      logic [15:0]  stamp;
      logic [15:0]  stamp_out;
      logic         stamp_wr;
      logic [7:0]   secondary;
      logic [7:0]   gated;
      logic [7:0]   rdata;
   } cmc_state_type;
endpackage : cmc_pkg

// >>> dv/cmc_bus_node_model.sv
// cmc_bus_node_model: other nodes on the shared bus, as the engine sees them
// assumes tasks are called from the bench; one bit time is four core cycles
`timescale 1ns/1ps
module cmc_bus_node_model (
   input  wire logic i_core_clk,
   output logic      o_rx_active,
   output logic      o_rx_valid_frame,
   output logic      o_eof_valid,
   output logic      o_bit_tick,
   output logic      o_recessive_bit,
   output logic      o_bus_activity
);
   // idle bus, nothing received
   initial begin
      o_rx_active      = 1'b0;
      o_rx_valid_frame = 1'b0;
      o_eof_valid      = 1'b0;
      o_bit_tick       = 1'b0;
      o_recessive_bit  = 1'b1;
      o_bus_activity   = 1'b0;
   end
   // bit runs at a chosen level, recessive or dominant
   // level flips between ticks so only the tick edge carries meaning
   task automatic bits(input int n, input logic lvl);
      for (int i = 0; i < n; i++) begin
         repeat (3) @(posedge i_core_clk);
         o_recessive_bit <= lvl;
         o_bit_tick      <= 1'b1;
         @(posedge i_core_clk);
         o_bit_tick      <= 1'b0;
         o_recessive_bit <= ~lvl;
      end
   endtask : bits
   task automatic pulse(input int which);
      @(posedge i_core_clk);
      o_rx_valid_frame <= (which == 0);
      o_eof_valid      <= (which == 1);
      o_bus_activity   <= (which == 2);
      @(posedge i_core_clk);
      o_rx_valid_frame <= 1'b0;
      o_eof_valid      <= 1'b0;
      o_bus_activity   <= 1'b0;
   endtask : pulse
   // receiver front end busy level
   task automatic set_rx(input logic v);
      @(posedge i_core_clk);
      o_rx_active <= v;
   endtask : set_rx
endmodule : cmc_bus_node_model

// >>> dv/cmc_mode_control_tb_top.sv
// cmc_mode_control_tb_top: self-checking bench of the mode control block
// assumes the bus node model drives the receive, bit and bus activity inputs
`timescale 1ns/1ps
module cmc_mode_control_tb_top;
   logic                 clk;
   logic                 rst;
   cmc_pkg::cmc_bus_type bus;
   logic [7:0]           rdata;
   logic                 rxa, rxv, eof, tick, rec, act;
   logic                 tx_empty, wake_flag, wait_mode, tx_data, bus_off;
   logic                 pin, clk_stop, abort, regs_rst, wake_ev, stamp_wr;
   logic [15:0]          stamp;
   logic [7:0]           d, r, sec, gat;
   int                   error_cnt, n_checks, n;
   // core clock 40 MHz
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   cmc_bus_node_model node (.i_core_clk(clk), .o_rx_active(rxa),
      .o_rx_valid_frame(rxv), .o_eof_valid(eof), .o_bit_tick(tick),
      .o_recessive_bit(rec), .o_bus_activity(act));
   cmc_mode_control dut (.i_core_clk(clk), .i_sys_rst(rst), .i_bus(bus),
      .o_rdata(rdata), .i_rx_active(rxa), .i_rx_valid_frame(rxv),
      .i_eof_valid(eof), .i_bit_tick(tick), .i_recessive_bit(rec),
      .i_bus_off(bus_off), .i_bus_activity(act), .i_tx_empty(tx_empty),
      .i_wake_flag(wake_flag), .i_wait_mode(wait_mode), .i_tx_data(tx_data),
      .o_bus_transmit_pin(pin), .o_host_clk_stop(clk_stop),
      .o_proto_abort(abort), .o_init_regs_reset(regs_rst),
      .o_wake_event(wake_ev), .o_stamp(stamp), .o_stamp_wr(stamp_wr),
      .o_secondary(sec), .o_gated_config(gat));
   // verdict and end of run
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   // register port cycles, one strobe cycle each
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge clk);
      bus.rd   <= 1'b0;
      #1 v = rdata;
   endtask : rd
   // bounded poll of one register bit
   task automatic poll(input logic [3:0] a, input int b, input logic v);
      logic [7:0] q;
      for (int i = 0; i < 40; i++) begin
         rd(a, q);
         if (q[b] === v) break;
      end
      chk(q[b], v);
      if (q[b] !== v) conclude();
   endtask : poll
   // end of frame with the stamp strobe watched beside it
   task automatic eof_stamp(input logic [15:0] e);
      logic seen;
      seen = 1'b0;
      fork
         node.pulse(1);
         for (int i = 0; i < 8 && !seen; i++) begin
            @(posedge clk);
            #1 if (stamp_wr === 1'b1) begin
               seen = 1'b1;
               chk(stamp, e);
            end
         end
      join
      chk(seen, 1'b1);
   endtask : eof_stamp
   initial begin
      bus = '0; rst = 1'b1; tx_empty = 1'b1; wake_flag = 1'b0;
      wait_mode = 1'b0; tx_data = 1'b0; bus_off = 1'b0;
      error_cnt = 0; n_checks = 0;
      void'($urandom(19726));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rd(4'h0, d); chk(d, 8'h01);
      rd(4'h1, d); chk(d, 8'h11);
      chk(sec, 8'h11);
      rd(4'hf, d); chk(d, 8'h00);
      r = 8'($urandom());
      wr(4'h3, r); rd(4'h3, d); chk(d, r);
      chk(gat, r);
      chk(pin, 1'b1);
      wr(4'h0, 8'h09); rd(4'h0, d); chk(d, 8'h01);
      wr(4'h0, 8'h00); poll(4'h1, 0, 1'b0);
      wr(4'h3, ~r); rd(4'h3, d); chk(d, r);
      chk(gat, r);
      rd(4'h0, d); chk(d[4], 1'b0);
      node.bits(11, 1'b1); poll(4'h0, 4, 1'b1);
      tx_data <= 1'($urandom()); @(posedge clk);
      #1 chk(pin, tx_data);
      tx_data <= ~tx_data; @(posedge clk);
      #1 chk(pin, tx_data);
      n = 1 + $urandom() % 8;
      wr(4'h0, 8'h08); node.bits(n, 1'b0); eof_stamp(16'(n));
      wr(4'h0, 8'h00); wr(4'h0, 8'h08); eof_stamp(16'h0000);
      node.set_rx(1'b1); rd(4'h0, d); chk(d[6], 1'b1);
      node.pulse(0); node.set_rx(1'b0);
      rd(4'h0, d); chk(d[7:6], 2'b10);
      wr(4'h0, 8'h00); rd(4'h0, d); chk(d[7], 1'b1);
      wr(4'h0, 8'h80); rd(4'h0, d); chk(d[7], 1'b0);
      wr(4'h0, 8'h20); wait_mode <= 1'b1;
      @(posedge clk); #1 chk(clk_stop, 1'b1);
      wait_mode <= 1'b0; wr(4'h0, 8'h00); wait_mode <= 1'b1;
      @(posedge clk); #1 chk(clk_stop, 1'b0);
      wait_mode <= 1'b0; wake_flag <= 1'b1;
      wr(4'h0, 8'h02); rd(4'h0, d); chk(d[1], 1'b0);
      wake_flag <= 1'b0; node.set_rx(1'b1);
      // wake enable set before the sleep request
      wr(4'h0, 8'h04); wr(4'h0, 8'h06);
      repeat (4) @(posedge clk);
      rd(4'h1, d); chk(d[1], 1'b0);
      wr(4'h0, 8'h04); rd(4'h0, d); chk(d[1], 1'b1);
      tx_empty <= 1'b0; node.set_rx(1'b0);
      rd(4'h1, d); chk(d[1], 1'b0);
      tx_empty <= 1'b1; poll(4'h1, 1, 1'b1);
      node.pulse(2); poll(4'h0, 1, 1'b0);
      wr(4'h0, 8'h00);
      @(posedge clk);
      bus <= '{addr: 4'h0, wdata: 8'h01, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wdata <= 8'h00;
      @(posedge clk);
      bus.wr <= 1'b0;
      rd(4'h0, d); chk(d[4:0], 5'h01);
      chk({abort, regs_rst, pin}, 3'b111);
      bus_off <= 1'b1; wr(4'h0, 8'h00);
      node.bits(11, 1'b1); rd(4'h0, d); chk(d[4], 1'b0);
      node.bits(126 * 11, 1'b1); bus_off <= 1'b0;
      repeat (2) @(posedge clk);
      rd(4'h0, d); chk(d[4], 1'b0);
      node.bits(11, 1'b1); poll(4'h0, 4, 1'b1);
      conclude();
   end
endmodule : cmc_mode_control_tb_top
